// *** hw/reset_lvd_pkg.sv ***
// Constants for the reset and low-voltage supervision block
package reset_lvd_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // Reset-delay prescaler: overflow after 131,072 cycles
  localparam int unsigned DELAY_COUNT_W = 17;
  localparam int unsigned DELAY_CYCLES = 131072;
  // Reset pin noise filter
  localparam int unsigned FILTER_NS = 400;
  localparam int unsigned FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_W = 5;
  // Reset values of the configuration bits and the low-voltage flags
  localparam logic THRESH_SEL_RST = 1'b1;
  localparam logic SOURCE_SEL_RST = 1'b1;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  // Compare source encoding
  localparam logic SOURCE_INTERNAL = 1'b1;
  localparam logic SOURCE_EXTERNAL = 1'b0;
endpackage : reset_lvd_pkg

// *** hw/sync2.sv ***
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // sync2
`default_nettype wire

// *** hw/reset_and_low_voltage_detect.sv ***
// Reset sequencer with low-voltage reset and low-voltage interrupt detection
//
// Summary of operation
// - Low reset pin holds the prescaler and chip in reset.
// - After pin release prescaler counts; overflow after 131,072 cycles frees reset.
// - Reset pin filtered; pulses under about 400 ns are ignored.
// - Low-voltage reset is always enabled; software cannot disable it.
// - Supply below selected reset threshold drives low_volt_reset_n low, clears prescaler.
// - Supply recovery raises low_volt_reset_n; reset frees after 131,072 cycles.
// - Low-voltage reset returns threshold select to 3.6 V; source select kept.
// - After power-on, detector active but both interrupt enables cleared.
// - Internal mode: supply below fall threshold drops event, sets fall flag, irq if enabled.
// - Internal mode: rise above 4.0 V raises event; rise enable sets flag and irq.
// - External mode: fall pin low drops event, sets fall flag, irq if enabled.
// - External mode: rise pin high raises event; rise enable sets flag and irq.
// - Watchdog flag reads 1 after watchdog reset, 0 after other resets.
// - Software reads reset flags, writes 0; device clears the written flag.
// - Supply below 100 mV makes the next rise a full power-on reset.
// - Fall and rise flags clear by writing 0 after reading 1, or by watchdog reset.
// - Power flag set by power-on or low-voltage reset, cleared by writing 0.
// - Watchdog flag cleared by power, low-voltage, pin reset or writing 0.
// - Low-voltage flags survive low-voltage and pin resets; threshold select survives pin reset only.
`timescale 1ns/1ps
`default_nettype none
module reset_and_low_voltage_detect
  import reset_lvd_pkg::*;
(
  // Clock and power-on reset (asserted after supply dropped below 100 mV)
  input wire logic clk,
  input wire logic nrst,
  // Reset sources
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_reset,
  // Comparators: below_* high while supply is below its threshold, above_rise_int high above it
  input wire logic below_reset_hi,
  input wire logic below_reset_lo,
  input wire logic below_fall_int,
  input wire logic above_rise_int,
  input wire logic fall_sense_pin,
  input wire logic rise_sense_pin,
  // Configuration writes
  input wire logic cfg_we,
  input wire logic reset_threshold_select_wd,
  input wire logic compare_source_select_wd,
  input wire logic fall_irq_enable_wd,
  input wire logic rise_irq_enable_wd,
  // Status flag access
  input wire logic status_rd,
  input wire logic status_we,
  input wire logic supply_fall_flag_wd,
  input wire logic supply_rise_flag_wd,
  input wire logic source_we,
  input wire logic power_reset_seen_wd,
  input wire logic watchdog_reset_seen_wd,
  // Outputs
  output logic internal_reset_n,
  output logic delay_count_overflow,
  output logic low_volt_reset_n,
  output logic low_volt_event_n,
  output logic external_irq_zero,
  output logic reset_threshold_select,
  output logic compare_source_select,
  output logic fall_irq_enable,
  output logic rise_irq_enable,
  output logic supply_fall_flag,
  output logic supply_rise_flag,
  output logic power_reset_seen,
  output logic watchdog_reset_seen
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [5:0] cmp_s;
  logic pin_s;

  sync2 #(.W(7)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({ext_reset_pin_n, rise_sense_pin, fall_sense_pin, above_rise_int,
               below_fall_int, below_reset_lo, below_reset_hi}),
    .sync_out({pin_s, cmp_s})
  );

  logic s_reset_hi, s_reset_lo, s_fall_int, s_rise_int, s_fall_pin, s_rise_pin;
  assign s_reset_hi = cmp_s[0];
  assign s_reset_lo = cmp_s[1];
  assign s_fall_int = cmp_s[2];
  assign s_rise_int = cmp_s[3];
  assign s_fall_pin = cmp_s[4];
  assign s_rise_pin = cmp_s[5];

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin filter and reset sequencing
  logic pin_filt_q, pin_filt_d;
  logic [FILTER_W-1:0] filt_cnt_q, filt_cnt_d;
  logic lvr_n_q, lvr_n_d;
  logic [DELAY_COUNT_W-1:0] delay_q, delay_d;
  logic ovf_q, ovf_d;
  logic wdt_hold_q, wdt_hold_d;
  logic below_reset;
  logic reset_req;

  // Threshold selected; recovery always judged at the high threshold
  assign below_reset = lvr_n_q ? (reset_threshold_select ? s_reset_hi : s_reset_lo)
                               : s_reset_hi;
  assign reset_req = !pin_filt_q || !lvr_n_q || wdt_hold_q;

  always_comb
  begin
    pin_filt_d = pin_filt_q;
    filt_cnt_d = '0;
    if (pin_s != pin_filt_q)
    begin
      filt_cnt_d = filt_cnt_q + 1'b1;
      if (filt_cnt_q == FILTER_W'(FILTER_CYCLES - 1))
      begin
        pin_filt_d = pin_s;
        filt_cnt_d = '0;
      end
    end
    lvr_n_d = !below_reset;
    wdt_hold_d = watchdog_reset;
    delay_d = delay_q;
    ovf_d = ovf_q;
    if (reset_req || watchdog_reset)
    begin
      delay_d = '0;
      ovf_d = 1'b0;
    end
    else if (!ovf_q)
    begin
      delay_d = delay_q + 1'b1;
      if (delay_q == DELAY_COUNT_W'(DELAY_CYCLES - 1))
      begin
        ovf_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_filt_q <= 1'b0;
      filt_cnt_q <= '0;
      lvr_n_q <= 1'b1;
      wdt_hold_q <= 1'b0;
      delay_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      pin_filt_q <= pin_filt_d;
      filt_cnt_q <= filt_cnt_d;
      lvr_n_q <= lvr_n_d;
      wdt_hold_q <= wdt_hold_d;
      delay_q <= delay_d;
      ovf_q <= ovf_d;
    end
  end

  assign delay_count_overflow = ovf_q;
  assign internal_reset_n = ovf_q;
  assign low_volt_reset_n = lvr_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and low-voltage interrupt detection
  logic sel_q, sel_d, src_q, src_d, fen_q, fen_d, ren_q, ren_d;
  logic ff_q, ff_d, rf_q, rf_d, ev_n_q, ev_n_d;
  logic ff_read_q, ff_read_d, rf_read_q, rf_read_d;
  logic fall_cond, rise_cond, fall_set, rise_set;

  assign fall_cond = (src_q == SOURCE_INTERNAL) ? s_fall_int : !s_fall_pin;
  assign rise_cond = ((src_q == SOURCE_INTERNAL) ? s_rise_int : s_rise_pin)
                     && !s_reset_lo;
  assign fall_set = ev_n_q && fall_cond;
  assign rise_set = !ev_n_q && !fall_cond && rise_cond;

  always_comb
  begin
    sel_d = sel_q;
    src_d = src_q;
    fen_d = fen_q;
    ren_d = ren_q;
    ff_d = ff_q;
    rf_d = rf_q;
    ev_n_d = ev_n_q;
    ff_read_d = ff_read_q;
    rf_read_d = rf_read_q;
    if (cfg_we)
    begin
      sel_d = reset_threshold_select_wd;
      src_d = compare_source_select_wd;
      fen_d = fall_irq_enable_wd;
      ren_d = rise_irq_enable_wd;
    end
    if (status_rd)
    begin
      ff_read_d = ff_q;
      rf_read_d = rf_q;
    end
    if (status_we)
    begin
      if (!supply_fall_flag_wd && ff_read_q)
      begin
        ff_d = 1'b0;
      end
      if (!supply_rise_flag_wd && rf_read_q)
      begin
        rf_d = 1'b0;
      end
      ff_read_d = 1'b0;
      rf_read_d = 1'b0;
    end
    if (fall_set)
    begin
      ev_n_d = 1'b0;
      ff_d = 1'b1;
    end
    if (rise_set)
    begin
      ev_n_d = 1'b1;
      if (ren_q)
      begin
        rf_d = 1'b1;
      end
    end
    if (!lvr_n_q)
    begin
      sel_d = THRESH_SEL_RST;
    end
    if (wdt_hold_q)
    begin
      sel_d = THRESH_SEL_RST;
      src_d = SOURCE_SEL_RST;
      fen_d = IRQ_EN_RST;
      ren_d = IRQ_EN_RST;
      ff_d = FLAG_RST;
      rf_d = FLAG_RST;
      ev_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_q <= THRESH_SEL_RST;
      src_q <= SOURCE_SEL_RST;
      fen_q <= IRQ_EN_RST;
      ren_q <= IRQ_EN_RST;
      ff_q <= FLAG_RST;
      rf_q <= FLAG_RST;
      ev_n_q <= 1'b1;
      ff_read_q <= 1'b0;
      rf_read_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_d;
      src_q <= src_d;
      fen_q <= fen_d;
      ren_q <= ren_d;
      ff_q <= ff_d;
      rf_q <= rf_d;
      ev_n_q <= ev_n_d;
      ff_read_q <= ff_read_d;
      rf_read_q <= rf_read_d;
    end
  end

  assign reset_threshold_select = sel_q;
  assign compare_source_select = src_q;
  assign fall_irq_enable = fen_q;
  assign rise_irq_enable = ren_q;
  assign supply_fall_flag = ff_q;
  assign supply_rise_flag = rf_q;
  assign low_volt_event_n = ev_n_q;

  // Interrupt request pulse
  logic irq_q, irq_d;
  assign irq_d = (fall_set && fen_q) || (rise_set && ren_q);

  ////////////////////////////////////////////////////////////////////////////
  // Reset source flags
  logic power_reset_seen_q, power_reset_seen_d, watchdog_reset_seen_q, watchdog_reset_seen_d;

  always_comb
  begin
    power_reset_seen_d = power_reset_seen_q;
    watchdog_reset_seen_d = watchdog_reset_seen_q;
    if (source_we)
    begin
      if (!power_reset_seen_wd)
      begin
        power_reset_seen_d = 1'b0;
      end
      if (!watchdog_reset_seen_wd)
      begin
        watchdog_reset_seen_d = 1'b0;
      end
    end
    if (!lvr_n_q)
    begin
      power_reset_seen_d = 1'b1;
      watchdog_reset_seen_d = 1'b0;
    end
    if (!pin_filt_q)
    begin
      watchdog_reset_seen_d = 1'b0;
    end
    if (wdt_hold_q)
    begin
      watchdog_reset_seen_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      power_reset_seen_q <= 1'b1;
      watchdog_reset_seen_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      power_reset_seen_q <= power_reset_seen_d;
      watchdog_reset_seen_q <= watchdog_reset_seen_d;
      irq_q <= irq_d;
    end
  end

  assign power_reset_seen = power_reset_seen_q;
  assign watchdog_reset_seen = watchdog_reset_seen_q;
  assign external_irq_zero = irq_q;

endmodule // reset_and_low_voltage_detect
`default_nettype wire

// *** testbench/reset_lvd_assertions.sv ***
// Checker of the reset and low-voltage supervision block
`timescale 1ns/1ps
`default_nettype none
module reset_lvd_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic status_we,
  input wire logic supply_fall_flag_wd,
  input wire logic internal_reset_n,
  input wire logic delay_count_overflow,
  input wire logic low_volt_reset_n,
  input wire logic low_volt_event_n,
  input wire logic external_irq_zero,
  input wire logic reset_threshold_select,
  input wire logic fall_irq_enable,
  input wire logic rise_irq_enable,
  input wire logic supply_fall_flag,
  input wire logic supply_rise_flag,
  input wire logic watchdog_reset_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_pin_low;
    !ext_reset_pin_n [*8] ##1 !ext_reset_pin_n [*8] ##1 !ext_reset_pin_n [*8];
  endsequence
  sequence s_fall;
    $fell(low_volt_event_n);
  endsequence
  a_prescaler_restart: assert property ($rose(low_volt_reset_n) |->
    !delay_count_overflow [*8])
    else $error("prescaler not restarted after low voltage");
  a_pin_holds_reset: assert property (s_pin_low |=> !internal_reset_n)
    else $error("reset pin low did not hold reset");
  a_release_after_pin: assert property ($rose(internal_reset_n) |-> $past(ext_reset_pin_n, 16))
    else $error("reset released with pin not settled");
  a_irq_one_pulse: assert property (external_irq_zero |=> !external_irq_zero)
    else $error("interrupt pulse too long");
  a_irq_needs_enable: assert property (external_irq_zero |->
    $past(fall_irq_enable) || $past(rise_irq_enable))
    else $error("interrupt without enable");
  a_fall_sets_flag: assert property (s_fall |-> ##[0:1] supply_fall_flag)
    else $error("fall flag not set");
  a_rise_flag_enable: assert property ($rose(supply_rise_flag) |-> $past(rise_irq_enable))
    else $error("rise flag set while disabled");
  a_lvr_thresh_high: assert property (!low_volt_reset_n |-> ##[0:2] reset_threshold_select)
    else $error("threshold select not restored");
  a_lvr_holds_reset: assert property (!low_volt_reset_n |=> !internal_reset_n)
    else $error("low voltage did not hold reset");
  a_flag_clear_cause: assert property ($fell(supply_fall_flag) |->
    ($past(status_we) && !$past(supply_fall_flag_wd)) || $past(watchdog_reset, 2) ||
    !$past(internal_reset_n))
    else $error("fall flag cleared without cause");
  a_wdt_flag_set: assert property (watchdog_reset && ext_reset_pin_n |->
    ##[1:3] watchdog_reset_seen)
    else $error("watchdog flag not set");
endmodule // reset_lvd_assertions
bind reset_and_low_voltage_detect reset_lvd_assertions u_chk (.clk, .nrst, .ext_reset_pin_n,
  .watchdog_reset, .status_we, .supply_fall_flag_wd, .internal_reset_n, .delay_count_overflow,
  .low_volt_reset_n, .low_volt_event_n, .external_irq_zero, .reset_threshold_select,
  .fall_irq_enable, .rise_irq_enable, .supply_fall_flag, .supply_rise_flag,
  .watchdog_reset_seen);
`default_nettype wire

// *** testbench/reset_and_low_voltage_detect_tb_top.sv ***
// Testbench of the reset and low-voltage supervision block
`timescale 1ns/1ps
`default_nettype none
module reset_and_low_voltage_detect_tb_top;
  import reset_lvd_pkg::*;
  logic clk = 0, nrst = 0, ext_reset_pin_n = 1, watchdog_reset = 0, below_reset_hi = 0;
  logic below_reset_lo = 0, below_fall_int = 0, above_rise_int = 1, fall_sense_pin = 1;
  logic rise_sense_pin = 1, cfg_we = 0, reset_threshold_select_wd = 1;
  logic compare_source_select_wd = 1, fall_irq_enable_wd = 0, rise_irq_enable_wd = 0;
  logic status_rd = 0, status_we = 0, supply_fall_flag_wd = 0, supply_rise_flag_wd = 0;
  logic source_we = 0, power_reset_seen_wd = 0, watchdog_reset_seen_wd = 0;
  logic internal_reset_n, delay_count_overflow, low_volt_reset_n, low_volt_event_n;
  logic external_irq_zero, reset_threshold_select, compare_source_select, fall_irq_enable;
  logic rise_irq_enable, supply_fall_flag, supply_rise_flag, power_reset_seen;
  logic watchdog_reset_seen, seen;
  int err_total = 0, comparisons = 0, cyc = 0, n;
  logic [3:0] rows [4] = '{4'h9, 4'h2, 4'hC, 4'h7};
  reset_and_low_voltage_detect DUT (.clk, .nrst, .ext_reset_pin_n, .watchdog_reset,
    .below_reset_hi, .below_reset_lo, .below_fall_int, .above_rise_int, .fall_sense_pin,
    .rise_sense_pin, .cfg_we, .reset_threshold_select_wd, .compare_source_select_wd,
    .fall_irq_enable_wd, .rise_irq_enable_wd, .status_rd, .status_we, .supply_fall_flag_wd,
    .supply_rise_flag_wd, .source_we, .power_reset_seen_wd, .watchdog_reset_seen_wd,
    .internal_reset_n, .delay_count_overflow, .low_volt_reset_n, .low_volt_event_n,
    .external_irq_zero, .reset_threshold_select, .compare_source_select, .fall_irq_enable,
    .rise_irq_enable, .supply_fall_flag, .supply_rise_flag, .power_reset_seen,
    .watchdog_reset_seen);
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task chk(input string s, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task cfg(input logic [3:0] v);
    {reset_threshold_select_wd, compare_source_select_wd, fall_irq_enable_wd,
      rise_irq_enable_wd} = v;
    cfg_we = 1;
    step(1);
    cfg_we = 0;
  endtask
  task clr_flags;
    status_rd = 1;
    step(1);
    status_rd = 0;
    status_we = 1;
    step(1);
    status_we = 0;
    step(1);
  endtask
  task wait_irq;
    seen = 0;
    repeat (8)
    begin
      step(1);
      if (external_irq_zero === 1'b1) seen = 1;
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 200000)
    begin
      err_total++;
      stop_test;
    end
  end
  initial
  begin
    step(20);
    chk("reset", 12'h784, {internal_reset_n, low_volt_reset_n, low_volt_event_n,
      reset_threshold_select, compare_source_select, fall_irq_enable, rise_irq_enable,
      supply_fall_flag, supply_rise_flag, power_reset_seen, watchdog_reset_seen,
      external_irq_zero});
    nrst = 1;
    n = 0;
    while (internal_reset_n !== 1'b1 && n < 140000)
    begin
      step(1);
      n++;
    end
    comparisons++;
    if (n < DELAY_CYCLES || n > DELAY_CYCLES + 30)
    begin
      err_total++;
      $display("BAD release expected %0d seen %0d", DELAY_CYCLES, n);
    end
    ext_reset_pin_n = 0;
    step(14);
    ext_reset_pin_n = 1;
    step(30);
    chk("short pulse", 1, internal_reset_n);
    $display("reset tests done");
    foreach (rows[i])
    begin
      cfg(rows[i]);
      step(1);
      chk("config", rows[i], {reset_threshold_select, compare_source_select,
        fall_irq_enable, rise_irq_enable});
    end
    below_fall_int = 1;
    above_rise_int = 0;
    wait_irq;
    chk("fall", 3'h7, {seen, ~low_volt_event_n, supply_fall_flag});
    status_we = 1;
    step(1);
    status_we = 0;
    step(2);
    chk("unread clear", 1, supply_fall_flag);
    clr_flags;
    chk("read clear", 0, supply_fall_flag);
    below_fall_int = 0;
    above_rise_int = 1;
    wait_irq;
    chk("rise", 3'h7, {seen, low_volt_event_n, supply_rise_flag});
    rise_sense_pin = 0;
    cfg(4'h0);
    step(2000);
    clr_flags;
    cfg(4'h2);
    fall_sense_pin = 0;
    wait_irq;
    chk("ext fall", 3'h7, {seen, ~low_volt_event_n, supply_fall_flag});
    fall_sense_pin = 1;
    rise_sense_pin = 1;
    wait_irq;
    chk("ext rise", 3'h2, {seen, low_volt_event_n, supply_rise_flag});
    $display("detect tests done");
    watchdog_reset = 1;
    step(1);
    watchdog_reset = 0;
    step(4);
    chk("watchdog", 3'h6, {watchdog_reset_seen, reset_threshold_select, fall_irq_enable});
    ext_reset_pin_n = 0;
    step(30);
    chk("pin reset", 2'h0, {watchdog_reset_seen, internal_reset_n});
    ext_reset_pin_n = 1;
    source_we = 1;
    step(1);
    source_we = 0;
    step(1);
    chk("source clear", 0, power_reset_seen);
    cfg(4'h0);
    below_reset_hi = 1;
    below_reset_lo = 1;
    step(6);
    chk("low volt", 5'h05, {low_volt_reset_n, internal_reset_n, reset_threshold_select,
      compare_source_select, power_reset_seen});
    below_reset_hi = 0;
    below_reset_lo = 0;
    step(6);
    chk("recover", 2'h2, {low_volt_reset_n, internal_reset_n});
    $display("source tests done");
    stop_test;
  end
endmodule // reset_and_low_voltage_detect_tb_top
`default_nettype wire
